// file: inc/dual_buck_defs.svh
// Offsets, field positions and reset values of the dual buck configuration bank
`ifndef DUAL_BUCK_DEFS_SVH
`define DUAL_BUCK_DEFS_SVH
`define OFS_CHAN_A_MODE 8'h3f
`define OFS_CHAN_A_CONF 8'h40
`define OFS_CHAN_B_VOLT 8'h43
`define OFS_CHAN_B_STBY 8'h44
`define OFS_CHAN_B_SLEEP 8'h45
`define OFS_CHAN_B_MODE 8'h46
`define OFS_CHAN_B_CONF 8'h47
`define MODE_CODE_MSB 3
`define MODE_SLEEP_BIT 5
`define CONF_ILIM_BIT 0
`define CONF_FREQ_LSB 2
`define CONF_PHASE_LSB 4
`define CONF_SPEED_LSB 6
`define VOLT_RANGE_BIT 6
`define MODE_CODE_RST 4'h8
`define SETPOINT_RST 6'h00
`define FIELD2_RST 2'h0
`endif

// file: inc/dual_buck_pkg.sv
// Types shared by the dual buck configuration bank
`default_nettype none
package dual_buck_pkg;
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_SLEEP = 2'b10
  } pwr_state_e;

  typedef struct packed {
    logic [3:0] mode_code;
    logic sleep_state;
    logic ilim_low;
    logic [1:0] freq_sel;
    logic [1:0] phase_sel;
    logic [1:0] ramp_speed;
  } chan_cfg_s;

  typedef struct packed {
    logic [7:0] addr;
    logic wr_en;
    logic [7:0] wr_data;
    logic rd_en;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] rd_data;
    logic rd_valid;
  } reg_rsp_s;
endpackage
`default_nettype wire

// file: core/dual_buck_config_registers.sv
// Register bank configuring a buck pair as two channels or one single-phase channel
// Functional notes
// - Mode registers hold a 4-bit mode code; single-phase uses channel A's code for both.
// - Mode bit 5 picks Sleep state: 0 output off, 1 pulse-skip mode.
// - Config bit 0 picks current limit: 0 high, 1 low.
// - Config bits 3:2 hold switching frequency code, reset zero.
// - Config bits 5:4 hold phase clock select, reset zero.
// - Config bits 7:6 hold ramp speed code, reset zero.
// - Channel B normal register holds a 6-bit set point used in normal operation.
// - Normal register bit 6 is read-only range, fixed only at configuration load.
// - Channel B standby register holds a 6-bit set point used in Standby.
// - Standby register bit 6 mirrors the loaded range bit, read-only.
// - Channel B sleep register holds a 6-bit set point used in Sleep.
// - Sleep register bit 6 copies the loaded range bit, read-only.
`timescale 1ns/1ps
`default_nettype none
`include "dual_buck_defs.svh"
module dual_buck_config_registers
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire dual_buck_pkg::reg_req_s req,
  output dual_buck_pkg::reg_rsp_s rsp,
  // Configuration load and operating state
  input wire logic cfg_load,
  input wire logic cfg_range_b,
  input wire logic single_phase,
  input wire dual_buck_pkg::pwr_state_e pwr_state,
  // Regulator controls
  output dual_buck_pkg::chan_cfg_s chan_a_cfg,
  output dual_buck_pkg::chan_cfg_s chan_b_cfg,
  output logic [5:0] chan_b_active_setpoint,
  output logic chan_b_range,
  output logic chan_a_output_on,
  output logic chan_b_output_on
);
  import dual_buck_pkg::*;

  typedef struct packed {
    chan_cfg_s a;
    chan_cfg_s b;
    logic [5:0] b_norm;
    logic [5:0] b_stby;
    logic [5:0] b_sleep;
    logic b_range;
    chan_cfg_s b_eff;
    logic [5:0] b_active;
    logic a_on;
    logic b_on;
    reg_rsp_s rsp;
  } state_s;

  state_s state_reg;
  state_s state_next;

  function automatic logic [7:0] mode_byte(input chan_cfg_s c);
    mode_byte = {2'h0, c.sleep_state, 1'b0, c.mode_code};
  endfunction

  function automatic logic [7:0] conf_byte(input chan_cfg_s c);
    conf_byte = {c.ramp_speed, c.phase_sel, c.freq_sel, 1'b0, c.ilim_low};
  endfunction

  function automatic chan_cfg_s write_mode(input chan_cfg_s c, input logic [7:0] d);
    write_mode = c;
    write_mode.mode_code = d[`MODE_CODE_MSB:0];
    write_mode.sleep_state = d[`MODE_SLEEP_BIT];
  endfunction

  function automatic chan_cfg_s write_conf(input chan_cfg_s c, input logic [7:0] d);
    write_conf = c;
    write_conf.ilim_low = d[`CONF_ILIM_BIT];
    write_conf.freq_sel = d[`CONF_FREQ_LSB+:2];
    write_conf.phase_sel = d[`CONF_PHASE_LSB+:2];
    write_conf.ramp_speed = d[`CONF_SPEED_LSB+:2];
  endfunction

  always_comb
  begin
    state_next = state_reg;
    // Range bit only moves on a configuration load, never on a software write
    if (cfg_load)
    begin
      state_next.b_range = cfg_range_b;
    end
    if (req.wr_en)
    begin
      case (req.addr)
        `OFS_CHAN_A_MODE: state_next.a = write_mode(state_reg.a, req.wr_data);
        `OFS_CHAN_A_CONF: state_next.a = write_conf(state_reg.a, req.wr_data);
        `OFS_CHAN_B_VOLT: state_next.b_norm = req.wr_data[5:0];
        `OFS_CHAN_B_STBY: state_next.b_stby = req.wr_data[5:0];
        `OFS_CHAN_B_SLEEP: state_next.b_sleep = req.wr_data[5:0];
        `OFS_CHAN_B_MODE: state_next.b = write_mode(state_reg.b, req.wr_data);
        `OFS_CHAN_B_CONF: state_next.b = write_conf(state_reg.b, req.wr_data);
        default: ;
      endcase
    end
    state_next.rsp.rd_valid = req.rd_en;
    state_next.rsp.rd_data = 8'h00;
    if (req.rd_en)
    begin
      case (req.addr)
        `OFS_CHAN_A_MODE: state_next.rsp.rd_data = mode_byte(state_reg.a);
        `OFS_CHAN_A_CONF: state_next.rsp.rd_data = conf_byte(state_reg.a);
        `OFS_CHAN_B_VOLT: state_next.rsp.rd_data = {1'b0, state_reg.b_range, state_reg.b_norm};
        `OFS_CHAN_B_STBY: state_next.rsp.rd_data = {1'b0, state_reg.b_range, state_reg.b_stby};
        `OFS_CHAN_B_SLEEP: state_next.rsp.rd_data = {1'b0, state_reg.b_range, state_reg.b_sleep};
        `OFS_CHAN_B_MODE: state_next.rsp.rd_data = mode_byte(state_reg.b);
        `OFS_CHAN_B_CONF: state_next.rsp.rd_data = conf_byte(state_reg.b);
        default: state_next.rsp.rd_data = 8'h00;
      endcase
    end
    // Derived controls are taken from the stored values, so they lag a write by one cycle
    state_next.b_eff = state_reg.b;
    if (single_phase)
    begin
      state_next.b_eff.mode_code = state_reg.a.mode_code;
      state_next.b_eff.sleep_state = state_reg.a.sleep_state;
    end
    case (pwr_state)
      PWR_STANDBY: state_next.b_active = state_reg.b_stby;
      PWR_SLEEP: state_next.b_active = state_reg.b_sleep;
      default: state_next.b_active = state_reg.b_norm;
    endcase
    state_next.a_on = (pwr_state != PWR_SLEEP) || state_reg.a.sleep_state;
    state_next.b_on = (pwr_state != PWR_SLEEP) || state_next.b_eff.sleep_state;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
      state_reg.a.mode_code <= `MODE_CODE_RST;
      state_reg.b.mode_code <= `MODE_CODE_RST;
      state_reg.b_eff.mode_code <= `MODE_CODE_RST;
      state_reg.a_on <= 1'b1;
      state_reg.b_on <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rsp = state_reg.rsp;
  assign chan_a_cfg = state_reg.a;
  assign chan_b_cfg = state_reg.b_eff;
  assign chan_b_active_setpoint = state_reg.b_active;
  assign chan_b_range = state_reg.b_range;
  assign chan_a_output_on = state_reg.a_on;
  assign chan_b_output_on = state_reg.b_on;

  AST_MODE_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    req.wr_en && req.addr == `OFS_CHAN_A_MODE |=> chan_a_cfg.mode_code == $past(req.wr_data[3:0]))
    else $error("mode code not stored");
  AST_SINGLE_PHASE: assert property (@(posedge mclk) disable iff (!reset_n)
    single_phase |=> chan_b_cfg.mode_code == $past(state_reg.a.mode_code))
    else $error("single phase does not follow channel A mode");
  AST_SLEEP_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
    pwr_state == PWR_SLEEP && !state_reg.a.sleep_state |=> !chan_a_output_on)
    else $error("channel A on in sleep while off selected");
  AST_CONF_READ: assert property (@(posedge mclk) disable iff (!reset_n)
    req.wr_en && req.addr == `OFS_CHAN_B_CONF ##1 req.rd_en && !req.wr_en && req.addr == `OFS_CHAN_B_CONF
    |=> rsp.rd_data == ($past(req.wr_data, 2) & 8'hfd))
    else $error("config readback mismatch");
  AST_FREQ_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    !(req.wr_en && req.addr == `OFS_CHAN_A_CONF) |=> $stable(chan_a_cfg.freq_sel))
    else $error("frequency changed without a write");
  AST_PHASE_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    req.wr_en && req.addr == `OFS_CHAN_A_CONF |=> chan_a_cfg.phase_sel == $past(req.wr_data[5:4]))
    else $error("phase select not stored");
  AST_SPEED_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    req.wr_en && req.addr == `OFS_CHAN_A_CONF |=> chan_a_cfg.ramp_speed == $past(req.wr_data[7:6]))
    else $error("ramp speed not stored");
  AST_NORMAL_SETPOINT: assert property (@(posedge mclk) disable iff (!reset_n)
    pwr_state == PWR_NORMAL |=> chan_b_active_setpoint == $past(state_reg.b_norm))
    else $error("normal set point not applied");
  AST_RANGE_FIXED: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg_load |=> $stable(chan_b_range))
    else $error("range moved without configuration load");
  AST_STBY_RANGE: assert property (@(posedge mclk) disable iff (!reset_n)
    req.rd_en && req.addr == `OFS_CHAN_B_STBY |=> rsp.rd_data[6] == $past(chan_b_range) && !rsp.rd_data[7])
    else $error("standby range bit wrong");
  AST_SLEEP_SETPOINT: assert property (@(posedge mclk) disable iff (!reset_n)
    pwr_state == PWR_SLEEP |=> chan_b_active_setpoint == $past(state_reg.b_sleep))
    else $error("sleep set point not applied");
  AST_UNMAPPED: assert property (@(posedge mclk) disable iff (!reset_n)
    req.rd_en && !(req.addr inside {`OFS_CHAN_A_MODE, `OFS_CHAN_A_CONF, `OFS_CHAN_B_VOLT, `OFS_CHAN_B_STBY,
    `OFS_CHAN_B_SLEEP, `OFS_CHAN_B_MODE, `OFS_CHAN_B_CONF}) |=> rsp.rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule // dual_buck_config_registers
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the dual buck configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dual_buck_pkg::*;
  logic mclk;
  logic reset_n;
  reg_req_s req;
  reg_rsp_s rsp;
  logic cfg_load;
  logic cfg_range_b;
  logic single_phase;
  pwr_state_e pwr_state;
  chan_cfg_s chan_a_cfg;
  chan_cfg_s chan_b_cfg;
  logic [5:0] sp;
  logic chan_b_range;
  logic a_on;
  logic b_on;
  int err_total;
  int checks;
  int cycles;

  dual_buck_config_registers uut
  (
    .mclk(mclk), .reset_n(reset_n), .req(req), .rsp(rsp), .cfg_load(cfg_load), .cfg_range_b(cfg_range_b),
    .single_phase(single_phase), .pwr_state(pwr_state), .chan_a_cfg(chan_a_cfg), .chan_b_cfg(chan_b_cfg),
    .chan_b_active_setpoint(sp), .chan_b_range(chan_b_range), .chan_a_output_on(a_on), .chan_b_output_on(b_on)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard: the whole run needs under 100 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req.addr = a;
    req.wr_data = d;
    req.wr_en = 1'b1;
    @(negedge mclk);
    req.wr_en = 1'b0;
  endtask

  // Read data stands for one cycle only, so it is sampled at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    req.addr = a;
    req.rd_en = 1'b1;
    @(negedge mclk);
    req.rd_en = 1'b0;
    check("rd_valid", {15'h0, rsp.rd_valid}, 16'h1);
    check("rd_data", {8'h0, rsp.rd_data}, {8'h0, exp});
  endtask

  task automatic test_reset();
    rd(8'h3f, 8'h08);
    rd(8'h46, 8'h08);
    rd(8'h40, 8'h00);
    rd(8'h47, 8'h00);
    rd(8'h43, 8'h00);
    rd(8'h44, 8'h00);
    rd(8'h45, 8'h00);
    check("chan_a_cfg", {4'h0, chan_a_cfg}, 16'h0800);
    check("outputs_on", {14'h0, a_on, b_on}, 16'h3);
    $display("test reset done");
  endtask

  task automatic test_conf();
    // Write then read back to back, the tightest spacing the port allows
    @(negedge mclk);
    req.addr = 8'h47;
    req.wr_data = 8'hff;
    req.wr_en = 1'b1;
    @(negedge mclk);
    req.wr_en = 1'b0;
    req.rd_en = 1'b1;
    @(negedge mclk);
    req.rd_en = 1'b0;
    check("rd_valid", {15'h0, rsp.rd_valid}, 16'h1);
    check("rd_data", {8'h0, rsp.rd_data}, 16'h00fd);
    idle(2);
    check("chan_b_cfg", {4'h0, chan_b_cfg}, {4'h0, 4'h8, 1'b0, 1'b1, 2'h3, 2'h3, 2'h3});
    wr(8'h40, 8'h96);
    rd(8'h40, 8'h94);
    check("chan_a_cfg", {4'h0, chan_a_cfg}, {4'h0, 4'h8, 1'b0, 1'b0, 2'h1, 2'h1, 2'h2});
    $display("test conf done");
  endtask

  task automatic test_volt();
    wr(8'h43, 8'hff);
    wr(8'h44, 8'hea);
    wr(8'h45, 8'h55);
    rd(8'h43, 8'h3f);
    rd(8'h44, 8'h2a);
    rd(8'h45, 8'h15);
    @(negedge mclk);
    cfg_load = 1'b1;
    cfg_range_b = 1'b1;
    @(negedge mclk);
    cfg_load = 1'b0;
    cfg_range_b = 1'b0;
    check("chan_b_range", {15'h0, chan_b_range}, 16'h1);
    rd(8'h43, 8'h7f);
    rd(8'h44, 8'h6a);
    rd(8'h45, 8'h55);
    pwr_state = PWR_STANDBY;
    idle(3);
    check("setpoint", {10'h0, sp}, 16'h2a);
    pwr_state = PWR_SLEEP;
    idle(3);
    check("setpoint", {10'h0, sp}, 16'h15);
    pwr_state = PWR_NORMAL;
    idle(3);
    check("setpoint", {10'h0, sp}, 16'h3f);
    $display("test volt done");
  endtask

  task automatic test_mode();
    pwr_state = PWR_SLEEP;
    wr(8'h46, 8'hff);
    rd(8'h46, 8'h2f);
    idle(2);
    check("b_on pulse", {15'h0, b_on}, 16'h1);
    check("a_on off", {15'h0, a_on}, 16'h0);
    wr(8'h46, 8'h03);
    wr(8'h3f, 8'h25);
    idle(2);
    check("b_on off", {15'h0, b_on}, 16'h0);
    check("a_on pulse", {15'h0, a_on}, 16'h1);
    check("b_mode", {12'h0, chan_b_cfg.mode_code}, 16'h3);
    single_phase = 1'b1;
    idle(3);
    check("b_mode single", {12'h0, chan_b_cfg.mode_code}, 16'h5);
    check("b_on single", {15'h0, b_on}, 16'h1);
    single_phase = 1'b0;
    pwr_state = PWR_NORMAL;
    wr(8'h41, 8'hff);
    rd(8'h41, 8'h00);
    rd(8'h48, 8'h00);
    $display("test mode done");
  endtask

  initial
  begin
    reset_n = 1'b0;
    req = '0;
    cfg_load = 1'b0;
    cfg_range_b = 1'b0;
    single_phase = 1'b0;
    pwr_state = PWR_NORMAL;
    idle(6);
    reset_n = 1'b1;
    test_reset();
    test_conf();
    test_volt();
    test_mode();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
